// file: lad_detector.sv
// Loss of signal and alarm signal detector for one receive channel.
// Assumes one-cycle interval enables and comparator levels on clk_sys.
//
// Functional notes
// - Declare loss after N quiet below-threshold intervals
// - Clear after M good intervals, density 12.5%
// - Loss declare raises interrupt unless masked
// - T1 declare count 175 or 1544
// - E1 declare count 32 or 2048
// - T1 clear window 128, under 100 zeros
// - E1 clear window 32, under 16 zeros
// - Short haul 800 mVpp, clear 200 higher
// - Long haul level code, reset -46 dB
// - Strapped long haul: E1 -46, T1 -38
// - Receive fill drives all ones during loss
// - Receive fill swaps in reference clock
// - Transmit fill sends ones on reference timing
// - Loss detection runs in every loopback
// - Alarm detection only with recovery enabled
// - Criteria bit picks the loss declare count
// - E1 alarm: two 512-bit blocks under 3 zeros
// - T1 alarm: 8192-bit block under 9 zeros
`include "lad_regs.svh"

module lad_detector
  import lad_pkg::*;
(
  // Clock and reset
  input  wire logic           clk_sys,
  input  wire logic           rst,
  // Register port
  input  wire logic [7:0]     reg_addr,
  input  wire logic [31:0]    reg_wdata,
  input  wire logic           reg_we,
  input  wire logic           reg_re,
  output logic      [31:0]    reg_rdata,
  output logic                irq,
  // Receive line samples, one per pulse interval
  input  wire logic           bit_en,
  input  wire lad_rx_sample_t rx_sample,
  input  wire logic           rx_data_pos_in,
  input  wire logic           rx_data_neg_in,
  input  wire logic           rx_clock_level,
  // Master reference timing
  input  wire logic           ref_tick,
  input  wire logic           ref_clock_level,
  // Transmit path
  input  wire logic           tx_data_pos_in,
  input  wire logic           tx_data_neg_in,
  output logic                tx_line_pos,
  output logic                tx_line_neg,
  // Straps
  input  wire logic           hw_strap_mode,
  // Threshold selection to the analog front end
  output logic      [4:0]     loss_level_code,
  output logic      [3:0]     lh_hysteresis_db,
  output logic      [11:0]    sh_declare_mv,
  output logic      [11:0]    sh_clear_mv,
  // System side
  output logic                signal_loss_indicator,
  output logic                alarm_signal_status,
  output logic                rx_data_pos,
  output logic                rx_data_neg,
  output logic                recovered_clock_out
);

  // Register group
  lad_ctrl_t   ctrl_reg, ctrl_next;
  logic [4:0]  level_reg, level_next;
  logic [1:0]  int_stat_reg, int_stat_next;
  logic [1:0]  int_mask_reg, int_mask_next;
  logic [31:0] rdata_reg, rdata_next;
  // Loss detector group
  logic        los_reg, los_next;
  logic [11:0] nt_cnt_reg, nt_cnt_next;
  logic        win_act_reg, win_act_next;
  logic [7:0]  win_cnt_reg, win_cnt_next;
  logic [7:0]  marks_reg, marks_next;
  logic [7:0]  run_reg, run_next;
  // Alarm group
  logic        ais_reg, ais_next;
  logic [13:0] blk_cnt_reg, blk_cnt_next;
  logic [3:0]  blk_zero_reg, blk_zero_next;
  logic        prev_low_reg, prev_low_next;
  // Output group
  logic        phase_reg, phase_next;
  logic        rxp_reg, rxp_next;
  logic        rxn_reg, rxn_next;
  logic        rclk_reg, rclk_next;
  logic        txp_reg, txp_next;
  logic        txn_reg, txn_next;
  logic [4:0]  code_reg, code_next;

  logic [11:0] n_sel;
  logic [7:0]  m_sel;
  logic [7:0]  z_sel;
  logic [1:0]  ev;

  // Count selection from standard and criteria bit
  always_comb begin
    if (ctrl_reg.line_standard_select) begin
      n_sel = ctrl_reg.criteria_select ? `LAD_N_T1_CRIT1
                                       : `LAD_N_T1_CRIT0;
      m_sel = `LAD_M_T1;
      z_sel = `LAD_Z_T1;
    end else begin
      n_sel = ctrl_reg.criteria_select ? `LAD_N_E1_CRIT1
                                       : `LAD_N_E1_CRIT0;
      m_sel = `LAD_M_E1;
      z_sel = `LAD_Z_E1;
    end
  end

  // Loss detector; inputs are never gated by loopback
  always_comb begin
    los_next    = los_reg;
    nt_cnt_next = nt_cnt_reg;
    win_act_next = win_act_reg;
    win_cnt_next = win_cnt_reg;
    marks_next  = marks_reg;
    run_next    = run_reg;
    if (bit_en) begin
      if (!los_reg) begin
        win_act_next = 1'b0;
        if (rx_sample.mark || rx_sample.above_declare) begin
          nt_cnt_next = 12'h000;
        end else if (nt_cnt_reg + 12'h001 >= n_sel) begin
          los_next    = 1'b1;
          nt_cnt_next = 12'h000;
        end else begin
          nt_cnt_next = nt_cnt_reg + 12'h001;
        end
      end else if (!win_act_reg) begin
        // Window starts only on a received pulse
        if (rx_sample.mark && rx_sample.above_clear) begin
          win_act_next = 1'b1;
          win_cnt_next = 8'h01;
          marks_next   = 8'h01;
          run_next     = 8'h00;
        end
      end else begin
        win_cnt_next = win_cnt_reg + 8'h01;
        marks_next   = marks_reg + {7'h00, rx_sample.mark};
        run_next     = rx_sample.mark ? 8'h00 : run_reg + 8'h01;
        if (!rx_sample.above_clear || run_next >= z_sel) begin
          win_act_next = 1'b0;
        end else if (win_cnt_next == m_sel) begin
          win_act_next = 1'b0;
          if (marks_next >= (m_sel >> `LAD_DENSITY_SHIFT)) begin
            los_next = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      los_reg     <= 1'b0;
      nt_cnt_reg  <= 12'h000;
      win_act_reg <= 1'b0;
      win_cnt_reg <= 8'h00;
      marks_reg   <= 8'h00;
      run_reg     <= 8'h00;
    end else begin
      los_reg     <= los_next;
      nt_cnt_reg  <= nt_cnt_next;
      win_act_reg <= win_act_next;
      win_cnt_reg <= win_cnt_next;
      marks_reg   <= marks_next;
      run_reg     <= run_next;
    end
  end

  // Alarm signal detector; both E1 criteria share one block rule
  logic blk_end;
  logic blk_low;
  logic [3:0] zero_add;
  always_comb begin
    ais_next      = ais_reg;
    blk_cnt_next  = blk_cnt_reg;
    blk_zero_next = blk_zero_reg;
    prev_low_next = prev_low_reg;
    blk_end  = 1'b0;
    blk_low  = 1'b0;
    zero_add = blk_zero_reg;
    if (!ctrl_reg.cdr_enable) begin
      ais_next      = 1'b0;
      blk_cnt_next  = 14'h0000;
      blk_zero_next = 4'h0;
      prev_low_next = 1'b0;
    end else if (bit_en) begin
      // Saturate: only below-threshold counts matter
      if (!rx_sample.mark && blk_zero_reg != 4'hf) begin
        zero_add = blk_zero_reg + 4'h1;
      end
      blk_end = ctrl_reg.line_standard_select
              ? (blk_cnt_reg == `LAD_AIS_BLK_T1)
              : (blk_cnt_reg == `LAD_AIS_BLK_E1);
      blk_low = ctrl_reg.line_standard_select
              ? (zero_add < `LAD_AIS_Z_T1)
              : (zero_add < `LAD_AIS_Z_E1);
      if (blk_end) begin
        blk_cnt_next  = 14'h0000;
        blk_zero_next = 4'h0;
        prev_low_next = blk_low;
        if (ctrl_reg.line_standard_select) begin
          ais_next = blk_low;
        end else if (blk_low && prev_low_reg) begin
          ais_next = 1'b1;
        end else if (!blk_low && !prev_low_reg) begin
          ais_next = 1'b0;
        end
      end else begin
        blk_cnt_next  = blk_cnt_reg + 14'h0001;
        blk_zero_next = zero_add;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ais_reg      <= 1'b0;
      blk_cnt_reg  <= 14'h0000;
      blk_zero_reg <= 4'h0;
      prev_low_reg <= 1'b0;
    end else begin
      ais_reg      <= ais_next;
      blk_cnt_reg  <= blk_cnt_next;
      blk_zero_reg <= blk_zero_next;
      prev_low_reg <= prev_low_next;
    end
  end

  // Register file; hardware set wins over write-one clear
  always_comb begin
    ctrl_next     = ctrl_reg;
    level_next    = level_reg;
    int_mask_next = int_mask_reg;
    int_stat_next = int_stat_reg;
    rdata_next    = 32'h0000_0000;
    ev            = 2'h0;
    ev[`LAD_INT_LOS] = los_next & ~los_reg;
    ev[`LAD_INT_AIS] = ais_next & ~ais_reg;
    if (reg_we) begin
      case (reg_addr)
        `LAD_ADDR_CTRL:     ctrl_next = lad_ctrl_t'(reg_wdata[5:0]);
        `LAD_ADDR_LEVEL:    level_next = reg_wdata[4:0];
        `LAD_ADDR_INT_STAT: int_stat_next = int_stat_reg & ~reg_wdata[1:0];
        `LAD_ADDR_INT_MASK: int_mask_next = reg_wdata[1:0];
        default:            ;
      endcase
    end
    int_stat_next = int_stat_next | ev;
    if (reg_re) begin
      case (reg_addr)
        `LAD_ADDR_CTRL:     rdata_next = {26'h0, ctrl_reg};
        `LAD_ADDR_LEVEL:    rdata_next = {27'h0, level_reg};
        `LAD_ADDR_STATUS:   rdata_next = {30'h0, ais_reg, los_reg};
        `LAD_ADDR_INT_STAT: rdata_next = {30'h0, int_stat_reg};
        `LAD_ADDR_INT_MASK: rdata_next = {30'h0, int_mask_reg};
        default:            rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_reg     <= lad_ctrl_t'(`LAD_CTRL_RST);
      level_reg    <= `LAD_LEVEL_RST;
      int_stat_reg <= 2'h0;
      int_mask_reg <= `LAD_MASK_RST;
      rdata_reg    <= 32'h0000_0000;
    end else begin
      ctrl_reg     <= ctrl_next;
      level_reg    <= level_next;
      int_stat_reg <= int_stat_next;
      int_mask_reg <= int_mask_next;
      rdata_reg    <= rdata_next;
    end
  end

  // Output stage; fill alternates polarity like line ones
  logic rx_fill;
  logic tx_fill;
  always_comb begin
    rx_fill    = los_reg & ctrl_reg.rx_alarm_fill_enable;
    tx_fill    = los_reg & ctrl_reg.tx_alarm_fill_enable;
    phase_next = ref_tick ? ~phase_reg : phase_reg;
    if (rx_fill) begin
      rxp_next  = phase_reg;
      rxn_next  = ~phase_reg;
      rclk_next = ref_clock_level;
    end else begin
      rxp_next  = rx_data_pos_in;
      rxn_next  = rx_data_neg_in;
      rclk_next = rx_clock_level;
    end
    if (tx_fill) begin
      txp_next = phase_reg;
      txn_next = ~phase_reg;
    end else begin
      txp_next = tx_data_pos_in;
      txn_next = tx_data_neg_in;
    end
    // Straps override the software level in long haul
    if (hw_strap_mode) begin
      code_next = ctrl_reg.line_standard_select ? `LAD_STRAP_CODE_T1
                                                : `LAD_STRAP_CODE_E1;
    end else begin
      code_next = level_reg;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_reg <= 1'b0;
      rxp_reg   <= 1'b0;
      rxn_reg   <= 1'b0;
      rclk_reg  <= 1'b0;
      txp_reg   <= 1'b0;
      txn_reg   <= 1'b0;
      code_reg  <= `LAD_LEVEL_RST;
    end else begin
      phase_reg <= phase_next;
      rxp_reg   <= rxp_next;
      rxn_reg   <= rxn_next;
      rclk_reg  <= rclk_next;
      txp_reg   <= txp_next;
      txn_reg   <= txn_next;
      code_reg  <= code_next;
    end
  end

  assign reg_rdata             = rdata_reg;
  assign irq                   = |(int_stat_reg & int_mask_reg);
  assign signal_loss_indicator = los_reg;
  assign alarm_signal_status   = ais_reg;
  assign rx_data_pos           = rxp_reg;
  assign rx_data_neg           = rxn_reg;
  assign recovered_clock_out   = rclk_reg;
  assign tx_line_pos           = txp_reg;
  assign tx_line_neg           = txn_reg;
  assign loss_level_code       = code_reg;
  assign lh_hysteresis_db      = `LAD_LH_HYST_DB;
  assign sh_declare_mv         = `LAD_SH_DECLARE_MV;
  assign sh_clear_mv           = `LAD_SH_DECLARE_MV + `LAD_SH_HYST_MV;

  // Checks
  a_los_declare_count: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(los_reg) |-> $past(nt_cnt_reg) == $past(n_sel) - 12'h001)
    else $error("loss declared at wrong count");

  a_mark_restart_cnt: assert property (@(posedge clk_sys) disable iff (rst)
    (bit_en && !los_reg && rx_sample.mark) |=> nt_cnt_reg == 12'h000)
    else $error("mark did not restart quiet count");

  a_los_clear_window: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(los_reg) |-> $past(win_cnt_reg) == $past(m_sel) - 8'h01)
    else $error("loss cleared outside full window");

  a_irq_on_declare: assert property (@(posedge clk_sys) disable iff (rst)
    ($rose(los_reg) && int_mask_reg[`LAD_INT_LOS]) |-> irq)
    else $error("no interrupt on loss declare");

  a_rx_fill_ones: assert property (@(posedge clk_sys) disable iff (rst)
    (los_reg && ctrl_reg.rx_alarm_fill_enable && !ref_tick)
      |=> (rx_data_pos != rx_data_neg) ##1 (rx_data_pos != rx_data_neg))
    else $error("receive fill not all ones");

  a_fill_ref_clock: assert property (@(posedge clk_sys) disable iff (rst)
    (los_reg && ctrl_reg.rx_alarm_fill_enable)
      |=> recovered_clock_out == $past(ref_clock_level))
    else $error("reference clock not substituted");

  a_tx_fill_ones: assert property (@(posedge clk_sys) disable iff (rst)
    (los_reg && ctrl_reg.tx_alarm_fill_enable) |=> (tx_line_pos ^ tx_line_neg))
    else $error("transmit fill not all ones");

  a_ais_cdr_off: assert property (@(posedge clk_sys) disable iff (rst)
    !ctrl_reg.cdr_enable [*2] |-> !alarm_signal_status)
    else $error("alarm reported with recovery off");

endmodule

// file: lad_regs.svh
// Offsets, reset values and counts for the loss and alarm signal detector.
// Assumes a word-addressed plain register port with byte-address offsets.
`ifndef LAD_REGS_SVH
`define LAD_REGS_SVH

// Register byte addresses
`define LAD_ADDR_CTRL      8'h00
`define LAD_ADDR_LEVEL     8'h04
`define LAD_ADDR_STATUS    8'h08
`define LAD_ADDR_INT_STAT  8'h0c
`define LAD_ADDR_INT_MASK  8'h10

// Reset values
`define LAD_CTRL_RST       6'h00
`define LAD_LEVEL_RST      5'h15
`define LAD_MASK_RST       2'h0

// Interrupt bit positions
`define LAD_INT_LOS        0
`define LAD_INT_AIS        1

// Declare counts, no-transition intervals
`define LAD_N_T1_CRIT0     12'h0af
`define LAD_N_T1_CRIT1     12'h608
`define LAD_N_E1_CRIT0     12'h020
`define LAD_N_E1_CRIT1     12'h800

// Clear windows and consecutive-zero limits
`define LAD_M_T1           8'h80
`define LAD_M_E1           8'h20
`define LAD_Z_T1           8'h64
`define LAD_Z_E1           8'h10
`define LAD_DENSITY_SHIFT  3

// Strapped long-haul level codes
`define LAD_STRAP_CODE_E1  5'h15
`define LAD_STRAP_CODE_T1  5'h11

// Amplitude thresholds
`define LAD_SH_DECLARE_MV  12'h320
`define LAD_SH_HYST_MV     12'h0c8
`define LAD_LH_HYST_DB     4'h4

// Alarm signal blocks
`define LAD_AIS_BLK_E1     14'h01ff
`define LAD_AIS_BLK_T1     14'h1fff
`define LAD_AIS_Z_E1       4'h3
`define LAD_AIS_Z_T1       4'h9

`endif

// file: lad_pkg.sv
// Types shared by the loss and alarm signal detector.
// Assumes lad_regs.svh supplies the numeric constants.
package lad_pkg;

  typedef struct packed {
    logic long_haul;
    logic cdr_enable;
    logic tx_alarm_fill_enable;
    logic rx_alarm_fill_enable;
    logic criteria_select;
    logic line_standard_select;
  } lad_ctrl_t;

  typedef struct packed {
    logic mark;
    logic above_declare;
    logic above_clear;
  } lad_rx_sample_t;

endpackage

// file: lad_line_model.sv
// Far-side model: line front end slicing pulses, master reference clock.
// Assumes the bench chooses marks, signal level and interval spacing.
module lad_line_model
  import lad_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst,
  // Bench control
  input  wire logic            marks,
  input  wire logic            lvl,
  input  wire logic [1:0]      gap,
  // Toward the detector
  output logic                 bit_en,
  output lad_rx_sample_t       rx_sample,
  output logic                 rx_data_pos_in,
  output logic                 rx_data_neg_in,
  output logic                 rx_clock_level,
  output logic                 ref_tick,
  output logic                 ref_clock_level
);
  logic [1:0] cnt_reg;
  logic [1:0] tick_reg;

  // Gap above zero gives slow intervals, not every cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg         <= 2'h0;
      tick_reg        <= 2'h0;
      bit_en          <= 1'b0;
      ref_tick        <= 1'b0;
      ref_clock_level <= 1'b0;
      rx_clock_level  <= 1'b0;
    end else begin
      cnt_reg         <= (cnt_reg >= gap) ? 2'h0 : cnt_reg + 2'h1;
      bit_en          <= (cnt_reg >= gap);
      tick_reg        <= tick_reg + 2'h1;
      ref_tick        <= (tick_reg == 2'h3);
      ref_clock_level <= ref_clock_level ^ (tick_reg == 2'h3);
      rx_clock_level  <= ~rx_clock_level;
    end
  end

  // A mark always clears both amplitude thresholds
  assign rx_sample      = {marks, lvl | marks, lvl | marks};
  assign rx_data_pos_in = marks & rx_clock_level;
  assign rx_data_neg_in = marks & ~rx_clock_level;
endmodule

// file: lad_detector_tb.sv
// Self-checking bench for the loss and alarm signal detector.
// Assumes the line model supplies intervals and the reference clock.
`include "lad_regs.svh"

module lad_detector_tb
  import lad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic           clk_sys, rst, reg_we, reg_re, irq, bit_en, marks, lvl;
  logic           hw_strap_mode, ref_tick, ref_clock_level, rx_clock_level;
  logic           rx_data_pos_in, rx_data_neg_in, tx_line_pos, tx_line_neg;
  logic           signal_loss_indicator, alarm_signal_status, fill, r;
  logic           rx_data_pos, rx_data_neg, recovered_clock_out;
  logic [1:0]     gap;
  logic [3:0]     lh_hysteresis_db;
  logic [4:0]     loss_level_code;
  logic [7:0]     reg_addr;
  logic [11:0]    sh_declare_mv, sh_clear_mv;
  logic [31:0]    reg_wdata, reg_rdata, cv;
  lad_rx_sample_t rx_sample;
  int             n_errors, comparisons;
  int             nd[4] = '{32, 2048, 175, 1544};
  int             md[4] = '{32, 32, 128, 128};
  int             zd[4] = '{16, 16, 100, 100};

  lad_line_model line (.clk_sys, .rst, .marks, .lvl, .gap, .bit_en,
    .rx_sample, .rx_data_pos_in, .rx_data_neg_in, .rx_clock_level,
    .ref_tick, .ref_clock_level);

  // Transmit data held at ones so fill shows as a rail difference
  lad_detector dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_we,
    .reg_re, .reg_rdata, .irq, .bit_en, .rx_sample, .rx_data_pos_in,
    .rx_data_neg_in, .rx_clock_level, .ref_tick, .ref_clock_level,
    .tx_data_pos_in(1'b1), .tx_data_neg_in(1'b1), .tx_line_pos,
    .tx_line_neg, .hw_strap_mode, .loss_level_code, .lh_hysteresis_db,
    .sh_declare_mv, .sh_clear_mv, .signal_loss_indicator,
    .alarm_signal_status, .rx_data_pos, .rx_data_neg,
    .recovered_clock_out);

  task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clk_sys);
    reg_we    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdc(string what, logic [7:0] a, logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge clk_sys);
    reg_re   <= 1'b0;
    @(posedge clk_sys);
    chk(what, reg_rdata, exp);
  endtask

  // Runs n intervals; a stalled interval source ends the run
  task automatic run(logic m, logic l, int n);
    int k = 0;
    marks <= m;
    lvl   <= l;
    while (n > 0) begin
      @(posedge clk_sys);
      k++;
      if (bit_en) begin
        n--;
        k = 0;
      end
      if (k > 8) begin
        chk("interval", 0, 1);
        summarize();
      end
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    rst           = 1'b1;
    reg_addr      = 8'h00;
    reg_wdata     = 32'h0;
    reg_we        = 1'b0;
    reg_re        = 1'b0;
    marks         = 1'b1;
    lvl           = 1'b1;
    gap           = 2'h0;
    hw_strap_mode = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rdc("level rst", `LAD_ADDR_LEVEL, 32'h15);
    rdc("ctrl rst", `LAD_ADDR_CTRL, 32'h0);
    rdc("mask rst", `LAD_ADDR_INT_MASK, 32'h0);
    rdc("unmapped", 8'hfc, 32'h0);
    chk("code rst", loss_level_code, 5'h15);
    chk("sh declare", sh_declare_mv, 12'h320);
    chk("sh clear", sh_clear_mv, 12'h3e8);
    chk("lh hyst", lh_hysteresis_db, 4'h4);
    $display("test reset done");

    wr(`LAD_ADDR_LEVEL, 32'h3);
    for (int s = 0; s < 4; s++) begin
      hw_strap_mode <= s[1];
      wr(`LAD_ADDR_CTRL, 32'h20 | s[0]);
      // Code register lags the control write by one cycle
      @(posedge clk_sys);
      #1;
      chk("level code", loss_level_code,
          !s[1] ? 5'h03 : s[0] ? 5'h11 : 5'h15);
    end
    hw_strap_mode <= 1'b0;
    $display("test level done");

    // One pass per standard and criteria setting
    for (int i = 0; i < 4; i++) begin
      fill = i[0];
      gap <= (i == 0) ? 2'h2 : 2'h0;
      cv = {28'h0, fill, fill, i[0], i[1]};
      wr(`LAD_ADDR_CTRL, cv);
      wr(`LAD_ADDR_INT_MASK, i != 0);
      rdc("ctrl", `LAD_ADDR_CTRL, cv);
      run(0, 0, nd[i] - 5);
      run(1, 1, 1);
      run(0, 0, nd[i] - 1);
      #1;
      chk("restart", signal_loss_indicator, 1'b0);
      run(0, 0, 1);
      #1;
      chk("declare", signal_loss_indicator, 1'b1);
      rdc("status", `LAD_ADDR_STATUS, 32'h1);
      rdc("int stat", `LAD_ADDR_INT_STAT, 32'h1);
      chk("irq", irq, i != 0);
      @(posedge clk_sys);
      r = fill ? ref_clock_level : rx_clock_level;
      @(posedge clk_sys);
      chk("rclk", recovered_clock_out, r);
      chk("rx fill", rx_data_pos ^ rx_data_neg, fill);
      chk("tx fill", tx_line_pos ^ tx_line_neg, fill);
      wr(`LAD_ADDR_INT_STAT, 32'h3);
      #1;
      chk("irq clr", irq, 1'b0);
      run(1, 1, 10);
      run(0, 1, zd[i]);
      run(1, 1, 1);
      run(0, 1, zd[i] - 1);
      run(1, 1, md[i] - zd[i] - 1);
      #1;
      chk("window", signal_loss_indicator, 1'b1);
      run(1, 1, 1);
      #1;
      chk("clear", signal_loss_indicator, 1'b0);
      $display("test loss %0d done", i);
    end

    gap <= 2'h0;
    wr(`LAD_ADDR_CTRL, 32'h10);
    run(1, 1, 1030);
    chk("ais e1", alarm_signal_status, 1'b1);
    rdc("status ais", `LAD_ADDR_STATUS, 32'h2);
    run(0, 1, 1030);
    chk("ais e1 clr", alarm_signal_status, 1'b0);
    // Recovery off restarts the block count so T1 blocks align
    wr(`LAD_ADDR_CTRL, 32'h01);
    wr(`LAD_ADDR_CTRL, 32'h11);
    run(1, 1, 8200);
    chk("ais t1", alarm_signal_status, 1'b1);
    wr(`LAD_ADDR_CTRL, 32'h01);
    @(posedge clk_sys);
    #1;
    chk("ais off", alarm_signal_status, 1'b0);
    $display("test alarm done");
    summarize();
  end
endmodule
